// ### verilog/npr_map.vh
// Constants for the host-side NAND page-read controller.
// Assumes a 40 MHz system clock and a byte-wide multiplexed NAND device.
`ifndef NPR_MAP_VH
`define NPR_MAP_VH

// ======================================================================
// Register map (APB byte offsets)
`define NPR_REG_CTRL     8'h00
`define NPR_REG_ADDR     8'h04
`define NPR_REG_COUNT    8'h08
`define NPR_REG_STATUS   8'h0C
`define NPR_REG_DATA     8'h10
`define NPR_REG_BADBLK   8'h14

// ======================================================================
// Control fields: [2:0] operation, [3] start, [4] spare enable level.
`define NPR_OP_READ_A    3'h0
`define NPR_OP_READ_B    3'h1
`define NPR_OP_READ_C    3'h2
`define NPR_OP_ERASE     3'h3
`define NPR_OP_RESET     3'h4
`define NPR_OP_NEXT      3'h5
`define NPR_CTRL_START   3
`define NPR_CTRL_SPARE   4

// ======================================================================
// Device commands.
`define NPR_CMD_READ_A   8'h00
`define NPR_CMD_READ_B   8'h01
`define NPR_CMD_READ_C   8'h50
`define NPR_CMD_ERASE    8'h60
`define NPR_CMD_ERASE_GO 8'hD0
`define NPR_CMD_STATUS   8'h70
`define NPR_CMD_RESET    8'hFF

// ======================================================================
// Status byte fields.
`define NPR_SB_READY     6
`define NPR_SB_FAIL      0

// ======================================================================
// Timing: read strobe low lasts this many cycles (2 x 25 ns = 50 ns); write strobe low lasts one cycle.
`define NPR_PHASE_NS     50
`define NPR_CLK_NS       25
`define NPR_PHASE_CYC    ((`NPR_PHASE_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)
`define NPR_WB_NS        100
`define NPR_WB_CYC       ((`NPR_WB_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)

`endif

// ### verilog/npr_sync.v
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the input is a pin outside the clk_i domain.
`timescale 1ns/1ps
module npr_sync (
   input  wire clk_i,
   input  wire reset_n_i,
   input  wire d_i,
   output reg  q_o
);
   reg meta_q;

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= 1'b1;
         q_o    <= 1'b1;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule

// ### verilog/npr_host.v
// Host controller that drives a NAND device for page read and erase.
// Assumes an APB master on clk_i and an external pull-up on ready_busy.
`timescale 1ns/1ps
`include "npr_map.vh"
module npr_host (
   input  wire        clk_i,
   input  wire        reset_n_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   output reg         cle_o,
   output reg         ale_o,
   output reg         ce_n_o,
   output reg         we_n_o,
   output reg         read_strobe_n_o,
   output reg         spare_enable_n_o,
   output reg  [7:0]  io_o,
   output reg         io_oe_o,
   input  wire [7:0]  io_i,
   input  wire        ready_busy_i
);
   // ===================================================================
   // State encoding
   localparam S_IDLE  = 4'd0;
   localparam S_CMD   = 4'd1;
   localparam S_ADDR  = 4'd2;
   localparam S_WB    = 4'd3;
   localparam S_BUSY  = 4'd4;
   localparam S_READ  = 4'd5;
   localparam S_CMD2  = 4'd6;
   localparam S_STAT  = 4'd7;
   localparam S_SREAD = 4'd8;
   localparam S_DONE  = 4'd9;

   reg [3:0]  st_q;
   reg [2:0]  op_q;
   reg [23:0] addr_q;
   reg [9:0]  count_q;
   reg [1:0]  acyc_q;
   reg [1:0]  ph_q;
   reg [2:0]  wb_q;
   reg [7:0]  data_q;
   reg        dvalid_q;
   reg        busy_q;
   reg        fail_q;
   reg        bad_q;
   reg [9:0]  badblk_q;
   reg        mode_spare_q;
   reg [7:0]  cmd2_q;
   wire       rb_s;
   wire       apb_wr;
   wire       apb_rd;
   wire       apb_wacc;

   npr_sync u_rb (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .d_i       (ready_busy_i),
      .q_o       (rb_s)
   );

   // Writes commit on the completing edge, so a stalled master never half-writes.
   assign apb_wr   = psel_i & penable_i & pwrite_i & pready_o;
   assign apb_wacc = psel_i & penable_i & pwrite_i & ~pready_o;
   assign apb_rd = psel_i & penable_i & ~pwrite_i & ~pready_o;

   // Command byte for each operation.
   function [7:0] op_cmd;
      input [2:0] op;
      begin
         case (op)
            `NPR_OP_READ_B: op_cmd = `NPR_CMD_READ_B;
            `NPR_OP_READ_C: op_cmd = `NPR_CMD_READ_C;
            `NPR_OP_ERASE:  op_cmd = `NPR_CMD_ERASE;
            `NPR_OP_RESET:  op_cmd = `NPR_CMD_RESET;
            default:        op_cmd = `NPR_CMD_READ_A;
         endcase
      end
   endfunction

   // ===================================================================
   // APB slave: one wait state, answer in the cycle after access begins.
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         if (apb_rd) begin
            case (paddr_i)
               `NPR_REG_CTRL:   prdata_o <= {27'h000_0000, ~spare_enable_n_o, 1'b0, op_q};
               `NPR_REG_ADDR:   prdata_o <= {8'h00, addr_q};
               `NPR_REG_COUNT:  prdata_o <= {22'h00_0000, count_q};
               `NPR_REG_STATUS: prdata_o <= {26'h000_0000, mode_spare_q, rb_s, bad_q,
                                             fail_q, dvalid_q, busy_q};
               `NPR_REG_DATA:   prdata_o <= {24'h00_0000, data_q};
               `NPR_REG_BADBLK: prdata_o <= {22'h00_0000, badblk_q};
               default:         pslverr_o <= 1'b1;
            endcase
         end else if (apb_wacc && paddr_i != `NPR_REG_CTRL && paddr_i != `NPR_REG_ADDR
                      && paddr_i != `NPR_REG_COUNT) begin
            pslverr_o <= 1'b1;
         end
      end
   end

   // ===================================================================
   // Pin sequencer.
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= S_IDLE; op_q <= 3'h0; addr_q <= 24'h00_0000;
         count_q <= 10'h000; acyc_q <= 2'h0; ph_q <= 2'h0; wb_q <= 3'h0;
         data_q <= 8'h00; dvalid_q <= 1'b0; busy_q <= 1'b0; fail_q <= 1'b0;
         bad_q <= 1'b0; badblk_q <= 10'h000; mode_spare_q <= 1'b0; cmd2_q <= 8'h00;
         cle_o <= 1'b0; ale_o <= 1'b0; ce_n_o <= 1'b1; we_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1; spare_enable_n_o <= 1'b1;
         io_o <= 8'h00; io_oe_o <= 1'b0;
      end else begin
         if (apb_rd && paddr_i == `NPR_REG_DATA)
            dvalid_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               ph_q <= 2'h0;
               acyc_q <= 2'h0;
               if (apb_wr && paddr_i == `NPR_REG_ADDR)
                  addr_q <= pwdata_i[23:0];
               if (apb_wr && paddr_i == `NPR_REG_COUNT)
                  count_q <= pwdata_i[9:0];
               if (apb_wr && paddr_i == `NPR_REG_CTRL) begin
                  op_q <= pwdata_i[2:0];
                  spare_enable_n_o <= ~pwdata_i[`NPR_CTRL_SPARE];
                  if (pwdata_i[`NPR_CTRL_START]) begin
                     busy_q <= 1'b1;
                     ce_n_o <= 1'b0;
                     // A later page read needs a new address but no repeated command.
                     st_q <= (pwdata_i[2:0] == `NPR_OP_NEXT) ? S_ADDR : S_CMD;
                     if (pwdata_i[2:0] == `NPR_OP_READ_C)
                        mode_spare_q <= 1'b1;
                     else if (pwdata_i[2:0] == `NPR_OP_READ_A ||
                              pwdata_i[2:0] == `NPR_OP_READ_B ||
                              pwdata_i[2:0] == `NPR_OP_RESET)
                        mode_spare_q <= 1'b0;
                  end
               end
            end
            S_CMD: begin
               // One byte write cycle: setup, strobe low, strobe high.
               cle_o <= 1'b1; io_oe_o <= 1'b1; io_o <= op_cmd(op_q);
               ph_q <= ph_q + 2'h1;
               we_n_o <= (ph_q == 2'h1) ? 1'b0 : 1'b1;
               if (ph_q == 2'h3) begin
                  cle_o <= 1'b0;
                  acyc_q <= 2'h0;
                  ph_q <= 2'h0;
                  if (op_q == `NPR_OP_RESET)
                     st_q <= S_WB;
                  else
                     st_q <= S_ADDR;
               end
            end
            S_ADDR: begin
               ale_o <= 1'b1; io_oe_o <= 1'b1;
               ph_q <= ph_q + 2'h1;
               we_n_o <= (ph_q == 2'h1) ? 1'b0 : 1'b1;
               // Erase takes two row bytes only; reads take column then two rows.
               case (acyc_q + ((op_q == `NPR_OP_ERASE) ? 2'h1 : 2'h0))
                  2'h0: io_o <= mode_spare_q ? {4'h0, addr_q[3:0]} : addr_q[7:0];
                  2'h1: io_o <= addr_q[15:8];
                  default: io_o <= addr_q[23:16];
               endcase
               if (ph_q == 2'h3) begin
                  ph_q <= 2'h0;
                  acyc_q <= acyc_q + 2'h1;
                  if (acyc_q == ((op_q == `NPR_OP_ERASE) ? 2'h1 : 2'h2)) begin
                     ale_o <= 1'b0;
                     cmd2_q <= `NPR_CMD_ERASE_GO;
                     st_q <= (op_q == `NPR_OP_ERASE) ? S_CMD2 : S_WB;
                  end
               end
            end
            S_CMD2: begin
               cle_o <= 1'b1; io_oe_o <= 1'b1; io_o <= cmd2_q;
               ph_q <= ph_q + 2'h1;
               we_n_o <= (ph_q == 2'h1) ? 1'b0 : 1'b1;
               if (ph_q == 2'h3) begin
                  cle_o <= 1'b0; ph_q <= 2'h0;
                  if (cmd2_q == `NPR_CMD_STATUS) begin
                     io_oe_o <= 1'b0; st_q <= S_STAT;
                  end else begin
                     cmd2_q <= `NPR_CMD_STATUS; st_q <= S_WB;
                  end
               end
            end
            S_WB: begin
               // Let ready/busy fall before it is watched.
               io_oe_o <= 1'b0;
               wb_q <= wb_q + 3'h1;
               if (wb_q == `NPR_WB_CYC) begin
                  wb_q <= 3'h0;
                  st_q <= S_BUSY;
               end
            end
            S_BUSY: begin
               ph_q <= 2'h0;
               if (rb_s) begin
                  if (op_q == `NPR_OP_ERASE)
                     st_q <= S_CMD2;
                  else if (op_q == `NPR_OP_RESET)
                     st_q <= S_DONE;
                  else
                     st_q <= S_SREAD;
               end
            end
            S_SREAD: begin
               // Wait for the previous byte to be taken by software.
               ph_q <= 2'h0;
               if (count_q == 10'h000)
                  st_q <= S_DONE;
               else if (!dvalid_q && rb_s)
                  st_q <= S_READ;
            end
            S_READ: begin
               ph_q <= ph_q + 2'h1;
               read_strobe_n_o <= (ph_q == 2'h0 || ph_q == 2'h1) ? 1'b0 : 1'b1;
               if (ph_q == 2'h2) begin
                  data_q <= io_i; dvalid_q <= 1'b1;
                  count_q <= count_q - 10'h001;
               end
               if (ph_q == 2'h3)
                  st_q <= S_SREAD;
            end
            S_STAT: begin
               ph_q <= ph_q + 2'h1;
               read_strobe_n_o <= (ph_q == 2'h0 || ph_q == 2'h1) ? 1'b0 : 1'b1;
               if (ph_q == 2'h2) begin
                  if (io_i[`NPR_SB_READY]) begin
                     fail_q <= io_i[`NPR_SB_FAIL];
                     if (io_i[`NPR_SB_FAIL]) begin
                        // Failing block is retired by software from this record.
                        bad_q <= 1'b1; badblk_q <= addr_q[17:8];
                     end
                  end
               end
               if (ph_q == 2'h3)
                  st_q <= (io_i[`NPR_SB_READY] || rb_s) ? S_DONE : S_STAT;
            end
            S_DONE: begin
               // Raising chip select ends any sequential row read.
               ce_n_o <= 1'b1;
               busy_q <= 1'b0;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ### tb/npr_host_checker.sv
// Checker on the host controller's ports for bus, strobe and spare-enable hazards.
// Assumes the host module's port names and a single clock domain.
`timescale 1ns/1ps
`include "npr_map.vh"
module npr_host_checker (
   input wire        clk_i,
   input wire        reset_n_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        cle_o,
   input wire        ale_o,
   input wire        ce_n_o,
   input wire        we_n_o,
   input wire        read_strobe_n_o,
   input wire        spare_enable_n_o,
   input wire        io_oe_o,
   input wire        ready_busy_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ======================================================================
   // Bus side.
   a_pready_one: assert property (pready_o |=> !pready_o)
      else $error("pready longer than a cycle");
   a_pready_wait: assert property (psel_i && !penable_i ##1 psel_i && penable_i |=> pready_o)
      else $error("pready late");
   a_unmapped_err: assert property (pready_o && paddr_i > `NPR_REG_BADBLK |-> pslverr_o)
      else $error("no error on unmapped");
   a_idle_rdata: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside answer");
   // ======================================================================
   // Flash pins.
   a_we_pulse: assert property ($fell(we_n_o) |-> !ce_n_o && (cle_o || ale_o) ##1 we_n_o && (cle_o || ale_o))
      else $error("write strobe shape");
   a_cmd_addr_excl: assert property (!(cle_o && ale_o))
      else $error("command and address latch together");
   a_re_shape: assert property ($fell(read_strobe_n_o) |=> !read_strobe_n_o ##1 read_strobe_n_o [*2])
      else $error("read strobe shape");
   a_re_ready: assert property ($fell(read_strobe_n_o) |-> ready_busy_i && !ce_n_o)
      else $error("read strobe while busy");
   a_re_bus_free: assert property (!read_strobe_n_o |-> !io_oe_o && we_n_o)
      else $error("host drives during read");
   a_se_stable: assert property (!ce_n_o && !$past(ce_n_o) |-> $stable(spare_enable_n_o))
      else $error("spare enable moved in operation");
   c_read: cover property ($fell(read_strobe_n_o));
   c_spare: cover property ($fell(read_strobe_n_o) && !spare_enable_n_o);
   c_err: cover property (pslverr_o);
endmodule
bind npr_host npr_host_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .cle_o(cle_o), .ale_o(ale_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
   .read_strobe_n_o(read_strobe_n_o), .spare_enable_n_o(spare_enable_n_o),
   .io_oe_o(io_oe_o), .ready_busy_i(ready_busy_i));

// ### tb/npr_flash_model.sv
// Behavioural model of the byte-wide flash device on the host's pins.
// Assumes the bench feeds it the host's byte and pulls ready/busy up.
`timescale 1ns/1ps
module npr_flash_model #(
   parameter T_READ_NS  = 800,
   parameter T_ERASE_NS = 2000
) (
   input  wire       cle_i,
   input  wire       ale_i,
   input  wire       ce_n_i,
   input  wire       we_n_i,
   input  wire       read_strobe_n_i,
   input  wire       spare_enable_n_i,
   input  wire       fail_i,
   input  wire [7:0] io_i,
   output wire [7:0] io_o,
   output reg        ready_busy_o = 1'b1
);
   // Power-up lands in main-area read on the first half.
   reg [1:0]  ptr_q = 2'd0;
   reg [1:0]  mode_q = 2'd0;
   reg [1:0]  na_q = 2'd0;
   reg [9:0]  col_q = 10'h000;
   reg [15:0] page_q = 16'h0000;
   reg [7:0]  dout_q = 8'h00;
   reg        drv_q = 1'b0;
   reg        fail_q = 1'b0;
   reg        rd_en_q = 1'b0;
   // A released bus shows the inverse so a late sample cannot pass by luck.
   assign io_o = drv_q ? dout_q : ~dout_q;
   function [7:0] fd(input [15:0] p, input [9:0] c);
      fd = c[7:0] ^ {c[9:8], 6'h15} ^ p[7:0] ^ p[15:8];
   endfunction
   always @(posedge we_n_i) begin
      if (!ce_n_i && cle_i) begin
         if (io_i == 8'h00 || io_i == 8'hFF) ptr_q = 2'd0;
         if (io_i == 8'h01) ptr_q = 2'd1;
         if (io_i == 8'h50) ptr_q = 2'd2;
         mode_q = (io_i == 8'h70) ? 2'd1 : (io_i == 8'h60) ? 2'd2 : 2'd0;
         if (io_i == 8'hD0) begin
            if (ptr_q == 2'd1) ptr_q = 2'd0;
            fail_q = fail_i;
            ready_busy_o = 1'b0;
            #(T_ERASE_NS) ready_busy_o = 1'b1;
         end
      end else if (!ce_n_i && ale_i && mode_q == 2'd0) begin
         if (na_q == 2'd0) col_q = (ptr_q == 2'd2) ? {6'h20, io_i[3:0]} : {ptr_q, io_i};
         if (na_q == 2'd1) page_q[7:0] = io_i;
         if (na_q == 2'd2) begin
            page_q[15:8] = io_i;
            if (ptr_q == 2'd1) ptr_q = 2'd0;
            rd_en_q = 1'b1;
            ready_busy_o = 1'b0;
            #(T_READ_NS) ready_busy_o = 1'b1;
         end
         na_q = na_q + 2'd1;
      end
   end
   // A fresh select takes a fresh address, so reads need no new command.
   always @(posedge ce_n_i) begin
      na_q = 2'd0;
      rd_en_q = 1'b0;
      drv_q = 1'b0;
   end
   always @(negedge read_strobe_n_i) if (!ce_n_i) begin
      drv_q = 1'b1;
      if (mode_q == 2'd1) dout_q = {1'b1, ready_busy_o, 5'h00, fail_q};
      else if (rd_en_q && ready_busy_o) begin
         dout_q = fd(page_q, col_q);
         col_q = col_q + 10'd1;
      end else dout_q = ~dout_q;
   end
   always @(posedge read_strobe_n_i) begin
      if (rd_en_q && col_q > ((spare_enable_n_i && ptr_q != 2'd2) ? 10'd511 : 10'd527)) begin
         page_q = page_q + 16'h0001;
         col_q = (ptr_q == 2'd2) ? 10'd512 : 10'd0;
         ready_busy_o = 1'b0;
      end
      #15 drv_q = 1'b0;
      if (!ready_busy_o) #(T_READ_NS) ready_busy_o = 1'b1;
   end
endmodule

// ### tb/npr_host_tb.sv
// Self-checking bench for the flash page-read host controller.
// Assumes the flash model on the pins and a pulled-up ready/busy line.
`timescale 1ns/1ps
`include "npr_map.vh"
module npr_host_tb;
   reg         clk_i, reset_n_i, psel_i, penable_i, pwrite_i, fail_r, err;
   reg  [7:0]  paddr_i;
   reg  [31:0] pwdata_i, seed, rd;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, cle_o, ale_o, ce_n_o, we_n_o, re_n, se_n, io_oe_o, rb;
   wire [7:0]  host_io, dev_io;
   integer     n_errors, compares, cyc, k;
   reg  [1:0]  tp;
   npr_host uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .cle_o(cle_o), .ale_o(ale_o), .ce_n_o(ce_n_o),
      .we_n_o(we_n_o), .read_strobe_n_o(re_n), .spare_enable_n_o(se_n), .io_o(host_io),
      .io_oe_o(io_oe_o), .io_i(dev_io), .ready_busy_i(rb));
   npr_flash_model dev (.cle_i(cle_o), .ale_i(ale_o), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
      .read_strobe_n_i(re_n), .spare_enable_n_i(se_n), .fail_i(fail_r), .io_i(host_io),
      .io_o(dev_io), .ready_busy_o(rb));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   function [31:0] xs(input [31:0] x);
      xs = x ^ (x << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   function [7:0] fd(input [15:0] p, input [9:0] c);
      fd = c[7:0] ^ {c[9:8], 6'h15} ^ p[7:0] ^ p[15:8];
   endfunction
   task summarize;
      begin
         $display("compares %0d mismatches %0d", compares, n_errors);
         if (n_errors == 0 && compares > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // A hang is cut short here; it counts as a mismatch.
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         summarize;
      end
   end
   task chk(input [8*6:1] nm, input [31:0] exp, input [31:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1'b1;
         @(posedge clk_i);
         while (pready_o !== 1'b1) @(posedge clk_i);
         rd = prdata_o;
         err = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task wait_st(input integer b, input v);
      begin
         rd = {32{~v}};
         while (rd[b] !== v) apb(1'b0, `NPR_REG_STATUS, 32'h0000_0000);
      end
   endtask
   // Expected bytes follow the pointer the bench tracks, across page ends.
   task rd_page(input [2:0] op, input sp, input [23:0] a, input [9:0] n);
      integer i;
      reg [9:0] c;
      reg [9:0] lst;
      reg [15:0] pg;
      begin
         if (op < 3'h3) tp = op[1:0];
         c = (tp == 2'd2) ? {6'h20, a[3:0]} : {tp, a[7:0]};
         lst = (sp || tp == 2'd2) ? 10'd527 : 10'd511;
         pg = a[23:8];
         apb(1'b1, `NPR_REG_ADDR, {8'h00, a});
         apb(1'b1, `NPR_REG_COUNT, {22'h0, n});
         apb(1'b1, `NPR_REG_CTRL, {27'h0, sp, 1'b1, op});
         for (i = 0; i < n; i = i + 1) begin
            wait_st(1, 1'b1);
            apb(1'b0, `NPR_REG_DATA, 32'h0000_0000);
            chk("data", {24'h0, fd(pg, c)}, rd);
            c = c + 10'd1;
            if (c > lst) begin
               pg = pg + 16'h0001;
               c = (tp == 2'd2) ? 10'd512 : 10'd0;
            end
         end
         wait_st(0, 1'b0);
         if (tp == 2'd1) tp = 2'd0;
      end
   endtask
   task erase(input [23:0] a, input f);
      begin
         fail_r <= f;
         apb(1'b1, `NPR_REG_ADDR, {8'h00, a});
         apb(1'b1, `NPR_REG_CTRL, {28'h0, 1'b1, `NPR_OP_ERASE});
         wait_st(0, 1'b0);
         chk("efail", {31'h0, f}, {31'h0, rd[2]});
         apb(1'b0, `NPR_REG_BADBLK, 32'h0000_0000);
         chk("badblk", f ? {22'h0, a[17:8]} : 32'h0000_0000, rd);
      end
   endtask
   initial begin
      {reset_n_i, psel_i, penable_i, pwrite_i, fail_r} = 5'h00;
      paddr_i = 8'h00;
      pwdata_i = 32'h0000_0000;
      {n_errors, compares, cyc, tp} = 0;
      seed = 32'hb71d_ef7a;
      repeat (2) @(posedge clk_i);
      chk("pins", 32'h0000_0078, {25'h0, ce_n_o, we_n_o, re_n, se_n, cle_o, ale_o, io_oe_o});
      reset_n_i <= 1'b1;
      apb(1'b0, `NPR_REG_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_0010, rd);
      apb(1'b1, 8'h40, 32'h0000_0001);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      rd_page(`NPR_OP_READ_A, 1'b0, 24'h0400FE, 10'd3);
      rd_page(`NPR_OP_READ_B, 1'b0, 24'h0123FE, 10'd4);
      rd_page(`NPR_OP_NEXT, 1'b0, 24'h020010, 10'd2);
      rd_page(`NPR_OP_READ_C, 1'b1, 24'h0077FE, 10'd4);
      rd_page(`NPR_OP_NEXT, 1'b1, 24'h030005, 10'd2);
      rd_page(`NPR_OP_READ_B, 1'b1, 24'h0500FF, 10'd3);
      apb(1'b1, `NPR_REG_CTRL, {28'h0, 1'b1, `NPR_OP_RESET});
      wait_st(0, 1'b0);
      tp = 2'd0;
      rd_page(`NPR_OP_NEXT, 1'b0, 24'h060042, 10'd2);
      for (k = 0; k < 8; k = k + 1) begin
         seed = xs(seed);
         rd_page((seed[29:28] == 2'd3) ? `NPR_OP_NEXT : {1'b0, seed[29:28]}, seed[24],
            seed[23:0], {8'h00, seed[27:26]} + 10'd1);
      end
      erase(24'h0A1B00, 1'b0);
      erase(24'h1C2D00, 1'b1);
      summarize;
   end
endmodule
